/* File: include/addr_gen_pkg.sv */
// Constants shared by the effective-address generator and its helper
package addr_gen_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_MODE_CTRL   = 8'h46;
	localparam logic [7:0]  IDX_X_START     = 8'h48;
	localparam logic [7:0]  IDX_X_END       = 8'h4a;
	localparam logic [7:0]  IDX_Y_START     = 8'h4c;
	localparam logic [7:0]  IDX_Y_END       = 8'h4e;
	localparam logic [7:0]  IDX_REV_MOD     = 8'h50;
	localparam logic [7:0]  IDX_HOLD_COUNT  = 8'h52;

	// ----------------------------------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int          MC_X_EN_BIT     = 15;
	localparam int          MC_Y_EN_BIT     = 14;
	localparam int          MC_REV_SEL_LSB  = 8;
	localparam int          MC_Y_SEL_LSB    = 4;
	localparam int          MC_X_SEL_LSB    = 0;
	localparam int          REV_EN_BIT      = 15;
	localparam logic [15:0] MODE_CTRL_MASK  = 16'hcfff;
	localparam logic [15:0] START_MASK      = 16'hfffe;
	localparam logic [15:0] END_SET         = 16'h0001;
	localparam logic [15:0] HOLD_MASK       = 16'h3fff;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam logic [15:0] STACK_RESET     = 16'h0800;
	localparam logic [3:0]  SEL_NONE        = 4'hf;
	localparam logic [3:0]  STACK_REG       = 4'hf;

	// ----------------------------------------------------------------
	// Addressing modes
	// ----------------------------------------------------------------
	localparam logic [2:0]  AM_FILE         = 3'h0;
	localparam logic [2:0]  AM_DIRECT       = 3'h1;
	localparam logic [2:0]  AM_IND          = 3'h2;
	localparam logic [2:0]  AM_POST         = 3'h3;
	localparam logic [2:0]  AM_PRE          = 3'h4;
	localparam logic [2:0]  AM_REGOFS       = 3'h5;
	localparam logic [2:0]  AM_LITOFS       = 3'h6;
	localparam int          FILE_ADDR_W     = 13;

	// ----------------------------------------------------------------
	// Dual-operand fetch operations and pointer set
	// ----------------------------------------------------------------
	localparam logic [2:0]  MO_IND          = 3'h0;
	localparam logic [2:0]  MO_POST2        = 3'h1;
	localparam logic [2:0]  MO_POST4        = 3'h2;
	localparam logic [2:0]  MO_POST6        = 3'h3;
	localparam logic [2:0]  MO_INDEX        = 3'h4;
	localparam logic [15:0] MAC_STEP2       = 16'h0002;
	localparam logic [15:0] MAC_STEP4       = 16'h0004;
	localparam logic [15:0] MAC_STEP6       = 16'h0006;
	localparam logic [3:0]  MAC_X_PTR_A     = 4'h8;
	localparam logic [3:0]  MAC_X_PTR_B     = 4'h9;
	localparam logic [3:0]  MAC_Y_PTR_A     = 4'ha;
	localparam logic [3:0]  MAC_Y_PTR_B     = 4'hb;
	localparam logic [3:0]  MAC_INDEX_REG   = 4'hc;

	// ----------------------------------------------------------------
	// Literal kinds
	// ----------------------------------------------------------------
	localparam logic [2:0]  LK_5            = 3'h0;
	localparam logic [2:0]  LK_10           = 3'h1;
	localparam logic [2:0]  LK_8            = 3'h2;
	localparam logic [2:0]  LK_16           = 3'h3;
	localparam logic [2:0]  LK_HOLD         = 3'h4;
	localparam logic [2:0]  LK_JUMP         = 3'h5;
	localparam logic [15:0] LIT5_MASK       = 16'h001f;
	localparam logic [15:0] LIT8_MASK       = 16'h00ff;
	localparam logic [15:0] LIT10_MASK      = 16'h03ff;

endpackage

/* File: rtl/ea_calc.sv */
// Effective address and pointer update for one address generator
`timescale 1ns/1ps
`default_nettype none
module ea_calc (
	// Request
	input  wire logic [2:0]                         mode,
	input  wire logic [3:0]                         ptr_sel,
	input  wire logic [addr_gen_pkg::FILE_ADDR_W-1:0] file_addr,
	// Operands
	input  wire logic [15:0]                        ptr_val,
	input  wire logic [15:0]                        ofs_val,
	input  wire logic [15:0]                        lit,
	input  wire logic [15:0]                        modifier,
	// Result
	output logic      [15:0]                        ea,
	output logic      [15:0]                        next_ptr,
	output logic                                    wb
);
	import addr_gen_pkg::*;

	always_comb begin
		ea = ptr_val;
		next_ptr = ptr_val;
		wb = 1'b0;
		case (mode)
			AM_FILE: begin
				ea = {3'h0, file_addr};
			end
			AM_DIRECT: begin
				ea = {11'h000, ptr_sel, 1'b0};
			end
			AM_POST: begin
				ea = ptr_val;
				next_ptr = ptr_val + modifier;
				wb = 1'b1;
			end
			AM_PRE: begin
				next_ptr = ptr_val + modifier;
				ea = ptr_val + modifier;
				wb = 1'b1;
			end
			AM_REGOFS: begin
				ea = ptr_val + ofs_val;
			end
			AM_LITOFS: begin
				ea = ptr_val + lit;
			end
			default: begin
				ea = ptr_val;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: rtl/address_generator_ea.sv */
// Effective-address generator with X/Y generators and addressing control registers
`timescale 1ns/1ps
`default_nettype none
module address_generator_ea (
	// Clock and reset
	input  wire logic                                 SYS_CLK,
	input  wire logic                                 RST_N,
	// AHB-Lite slave
	input  wire logic                                 HSEL,
	input  wire logic [31:0]                          HADDR,
	input  wire logic [1:0]                           HTRANS,
	input  wire logic                                 HWRITE,
	input  wire logic [2:0]                           HSIZE,
	input  wire logic [31:0]                          HWDATA,
	input  wire logic                                 HREADY,
	output logic      [31:0]                          HRDATA,
	output logic                                      HREADYOUT,
	output logic                                      HRESP,
	// Core writes to working registers
	input  wire logic                                 CORE_WR_EN,
	input  wire logic [3:0]                           CORE_WR_SEL,
	input  wire logic [15:0]                          CORE_WR_DATA,
	// General operand request
	input  wire logic                                 REQ_VALID,
	input  wire logic                                 REQ_PSPACE,
	input  wire logic                                 REQ_BYTE,
	input  wire logic                                 SRC_EN,
	input  wire logic [2:0]                           SRC_MODE,
	input  wire logic [3:0]                           SRC_PTR,
	input  wire logic [addr_gen_pkg::FILE_ADDR_W-1:0] SRC_FILE,
	input  wire logic                                 DST_EN,
	input  wire logic [2:0]                           DST_MODE,
	input  wire logic [3:0]                           DST_PTR,
	input  wire logic [addr_gen_pkg::FILE_ADDR_W-1:0] DST_FILE,
	input  wire logic                                 DST_TO_DEFAULT_WORK_REGISTER,
	input  wire logic [3:0]                           OFS_REG,
	input  wire logic [15:0]                          LIT_OFS,
	input  wire logic [15:0]                          MODIFIER,
	// Dual-operand fetch request
	input  wire logic                                 MAC_VALID,
	input  wire logic [3:0]                           MAC_X_PTR,
	input  wire logic [2:0]                           MAC_X_OP,
	input  wire logic [3:0]                           MAC_Y_PTR,
	input  wire logic [2:0]                           MAC_Y_OP,
	// Literal extraction
	input  wire logic                                 LIT_VALID,
	input  wire logic [2:0]                           LIT_KIND,
	input  wire logic [15:0]                          LIT_FIELD,
	// X generator outputs
	output logic                                      X_RD_VALID,
	output logic      [15:0]                          X_RD_ADDR,
	output logic                                      X_WR_VALID,
	output logic      [15:0]                          X_WR_ADDR,
	output logic                                      X_CIRC_ON,
	output logic                                      REV_ON,
	// Y generator outputs
	output logic                                      Y_RD_VALID,
	output logic      [15:0]                          Y_RD_ADDR,
	output logic                                      Y_CIRC_ON,
	output logic                                      MAC_FAULT,
	// Literal outputs
	output logic                                      LIT_OUT_VALID,
	output logic      [15:0]                          LIT_VALUE,
	output logic      [15:0]                          JUMP_OFFSET
);
	import addr_gen_pkg::*;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [15:0] mode_ctrl;
	logic [15:0] x_start;
	logic [15:0] x_end;
	logic [15:0] y_start;
	logic [15:0] y_end;
	logic [15:0] rev_mod;
	logic [15:0] hold_count;
	logic [15:0] default_work_register [16];

	wire logic       x_circ_en = mode_ctrl[MC_X_EN_BIT];
	wire logic       y_circ_en = mode_ctrl[MC_Y_EN_BIT];
	wire logic [3:0] x_sel     = mode_ctrl[MC_X_SEL_LSB +: 4];
	wire logic [3:0] y_sel     = mode_ctrl[MC_Y_SEL_LSB +: 4];
	wire logic [3:0] rev_sel   = mode_ctrl[MC_REV_SEL_LSB +: 4];
	wire logic       rev_en    = rev_mod[REV_EN_BIT];

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic       wr_pend;
	logic [7:0] wr_idx;

	wire logic       bus_go  = HSEL && HTRANS[1] && HREADY;
	wire logic [7:0] bus_idx = HADDR[9:2];
	wire logic       bus_hit = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);

	function automatic logic [15:0] reg_mask(input logic [7:0] idx);
		case (idx)
			IDX_MODE_CTRL:  reg_mask = MODE_CTRL_MASK;
			IDX_X_START:    reg_mask = START_MASK;
			IDX_X_END:      reg_mask = START_MASK;
			IDX_Y_START:    reg_mask = START_MASK;
			IDX_Y_END:      reg_mask = START_MASK;
			IDX_REV_MOD:    reg_mask = 16'hffff;
			IDX_HOLD_COUNT: reg_mask = HOLD_MASK;
			default:        reg_mask = 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] reg_set(input logic [7:0] idx);
		if (idx == IDX_X_END || idx == IDX_Y_END)
			reg_set = END_SET;
		else
			reg_set = 16'h0000;
	endfunction

	logic [15:0] rd_val;
	always_comb begin
		case (bus_idx)
			IDX_MODE_CTRL:  rd_val = mode_ctrl;
			IDX_X_START:    rd_val = x_start;
			IDX_X_END:      rd_val = x_end;
			IDX_Y_START:    rd_val = y_start;
			IDX_Y_END:      rd_val = y_end;
			IDX_REV_MOD:    rd_val = rev_mod;
			IDX_HOLD_COUNT: rd_val = hold_count;
			default:        rd_val = 16'h0000;
		endcase
		if (!bus_hit)
			rd_val = 16'h0000;
		else if (wr_pend && wr_idx == bus_idx)
			rd_val = (HWDATA[15:0] & reg_mask(bus_idx)) | reg_set(bus_idx);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
		end else if (HREADY) begin
			wr_pend <= bus_go && HWRITE && bus_hit;
			wr_idx <= bus_idx;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else if (bus_go && !HWRITE) begin
			HRDATA <= {16'h0000, rd_val};
		end
	end

	wire logic [15:0] wdat = HWDATA[15:0];

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_ctrl <= REG_RESET;
			x_start <= REG_RESET;
			x_end <= END_SET;
			y_start <= REG_RESET;
			y_end <= END_SET;
			rev_mod <= REG_RESET;
		end else if (wr_pend) begin
			case (wr_idx)
				IDX_MODE_CTRL: mode_ctrl <= wdat & MODE_CTRL_MASK;
				IDX_X_START:   x_start <= wdat & START_MASK;
				IDX_X_END:     x_end <= wdat | END_SET;
				IDX_Y_START:   y_start <= wdat & START_MASK;
				IDX_Y_END:     y_end <= wdat | END_SET;
				IDX_REV_MOD:   rev_mod <= wdat;
				default:       mode_ctrl <= mode_ctrl;
			endcase
		end
	end

	// The hold instruction wins over a bus write in the same cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			hold_count <= REG_RESET;
		else if (LIT_VALID && LIT_KIND == LK_HOLD)
			hold_count <= LIT_FIELD & HOLD_MASK;
		else if (wr_pend && wr_idx == IDX_HOLD_COUNT)
			hold_count <= wdat & HOLD_MASK;
	end

	// ------------------------------------------------------------
	// Dual-operand pointer checks
	// ------------------------------------------------------------
	function automatic logic [2:0] mac_mode(input logic [2:0] op);
		case (op)
			MO_POST2, MO_POST4, MO_POST6: mac_mode = AM_POST;
			MO_INDEX:                     mac_mode = AM_REGOFS;
			default:                      mac_mode = AM_IND;
		endcase
	endfunction

	function automatic logic [15:0] mac_step(input logic [2:0] op);
		case (op)
			MO_POST2: mac_step = MAC_STEP2;
			MO_POST4: mac_step = MAC_STEP4;
			MO_POST6: mac_step = MAC_STEP6;
			default:  mac_step = 16'h0000;
		endcase
	endfunction

	wire logic x_ptr_ok = (MAC_X_PTR == MAC_X_PTR_A) || (MAC_X_PTR == MAC_X_PTR_B);
	wire logic y_ptr_ok = (MAC_Y_PTR == MAC_Y_PTR_A) || (MAC_Y_PTR == MAC_Y_PTR_B);
	wire logic x_idx_ok = (MAC_X_OP != MO_INDEX) || (MAC_X_PTR == MAC_X_PTR_B);
	wire logic y_idx_ok = (MAC_Y_OP != MO_INDEX) || (MAC_Y_PTR == MAC_Y_PTR_B);
	wire logic x_op_ok  = MAC_X_OP <= MO_INDEX;
	wire logic y_op_ok  = MAC_Y_OP <= MO_INDEX;
	wire logic mac_ok   = x_ptr_ok && y_ptr_ok && x_idx_ok && y_idx_ok && x_op_ok && y_op_ok;
	wire logic mac_go   = MAC_VALID && mac_ok;
	wire logic gen_go   = REQ_VALID && !MAC_VALID;

	// ------------------------------------------------------------
	// Address generators
	// ------------------------------------------------------------
	wire logic [2:0]  xr_mode = MAC_VALID ? mac_mode(MAC_X_OP) : SRC_MODE;
	wire logic [3:0]  xr_sel  = MAC_VALID ? MAC_X_PTR : SRC_PTR;
	wire logic [15:0] xr_ofs  = MAC_VALID ? default_work_register[MAC_INDEX_REG] : default_work_register[OFS_REG];
	wire logic [15:0] xr_mod  = MAC_VALID ? mac_step(MAC_X_OP) : MODIFIER;
	logic [15:0] xr_ea;
	logic [15:0] xr_next;
	logic        xr_wb;
	logic [15:0] xw_ea;
	logic [15:0] xw_next;
	logic        xw_wb;
	logic [15:0] y_ea;
	logic [15:0] y_next;
	logic        y_wb;

	ea_calc u_x_read (
		.mode      (xr_mode),
		.ptr_sel   (xr_sel),
		.file_addr (SRC_FILE),
		.ptr_val   (default_work_register[xr_sel]),
		.ofs_val   (xr_ofs),
		.lit       (LIT_OFS),
		.modifier  (xr_mod),
		.ea        (xr_ea),
		.next_ptr  (xr_next),
		.wb        (xr_wb)
	);

	ea_calc u_x_write (
		.mode      (DST_MODE),
		.ptr_sel   (DST_PTR),
		.file_addr (DST_FILE),
		.ptr_val   (default_work_register[DST_PTR]),
		.ofs_val   (default_work_register[OFS_REG]),
		.lit       (LIT_OFS),
		.modifier  (MODIFIER),
		.ea        (xw_ea),
		.next_ptr  (xw_next),
		.wb        (xw_wb)
	);

	ea_calc u_y_read (
		.mode      (mac_mode(MAC_Y_OP)),
		.ptr_sel   (MAC_Y_PTR),
		.file_addr ({FILE_ADDR_W{1'b0}}),
		.ptr_val   (default_work_register[MAC_Y_PTR]),
		.ofs_val   (default_work_register[MAC_INDEX_REG]),
		.lit       (16'h0000),
		.modifier  (mac_step(MAC_Y_OP)),
		.ea        (y_ea),
		.next_ptr  (y_next),
		.wb        (y_wb)
	);

	wire logic xr_go = mac_go || (gen_go && SRC_EN);
	wire logic xw_go = gen_go && DST_EN;
	wire logic xr_upd = xr_go && xr_wb;
	wire logic xw_upd = xw_go && xw_wb && !(DST_MODE == AM_FILE);
	wire logic y_upd  = mac_go && y_wb;

	// ------------------------------------------------------------
	// Working registers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_default_work_register
			localparam logic [3:0] IDX = 4'(gi);
			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N)
					default_work_register[gi] <= (IDX == STACK_REG) ? STACK_RESET : REG_RESET;
				else if (CORE_WR_EN && CORE_WR_SEL == IDX)
					default_work_register[gi] <= CORE_WR_DATA;
				else if (xw_upd && DST_PTR == IDX)
					default_work_register[gi] <= xw_next;
				else if (xr_upd && xr_sel == IDX)
					default_work_register[gi] <= xr_next;
				else if (y_upd && MAC_Y_PTR == IDX)
					default_work_register[gi] <= y_next;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Circular and reversal qualification
	// ------------------------------------------------------------
	wire logic x_circ_ok = x_circ_en && (x_sel != SEL_NONE);
	wire logic y_circ_ok = y_circ_en && (y_sel != SEL_NONE);
	wire logic incr_mode = (DST_MODE == AM_POST || DST_MODE == AM_PRE) && !MODIFIER[15];
	wire logic rev_hit   = rev_en && (rev_sel != SEL_NONE) && incr_mode
		&& (DST_PTR == rev_sel) && !REQ_PSPACE && !REQ_BYTE;
	wire logic xr_ind    = xr_mode != AM_FILE && xr_mode != AM_DIRECT;
	wire logic xw_ind    = DST_MODE != AM_FILE && DST_MODE != AM_DIRECT;
	wire logic xr_circ   = xr_go && xr_ind && x_circ_ok && xr_sel == x_sel;
	// Reversal takes priority over circular on the X write side
	wire logic xw_circ   = xw_go && xw_ind && x_circ_ok && DST_PTR == x_sel && !rev_hit;

	// ------------------------------------------------------------
	// Address outputs
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			X_RD_VALID <= 1'b0;
			X_RD_ADDR <= 16'h0000;
			X_CIRC_ON <= 1'b0;
		end else begin
			X_RD_VALID <= xr_go;
			X_RD_ADDR <= mac_go ? {xr_ea[15:1], 1'b0} : xr_ea;
			X_CIRC_ON <= xr_circ || xw_circ;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			X_WR_VALID <= 1'b0;
			X_WR_ADDR <= 16'h0000;
			REV_ON <= 1'b0;
		end else begin
			X_WR_VALID <= xw_go;
			if (DST_MODE == AM_FILE && DST_TO_DEFAULT_WORK_REGISTER)
				X_WR_ADDR <= 16'h0000;
			else
				X_WR_ADDR <= xw_ea;
			REV_ON <= xw_go && rev_hit;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			Y_RD_VALID <= 1'b0;
			Y_RD_ADDR <= 16'h0000;
			Y_CIRC_ON <= 1'b0;
			MAC_FAULT <= 1'b0;
		end else begin
			Y_RD_VALID <= mac_go;
			Y_RD_ADDR <= {y_ea[15:1], 1'b0};
			Y_CIRC_ON <= mac_go && y_circ_ok && MAC_Y_PTR == y_sel;
			MAC_FAULT <= MAC_VALID && !mac_ok;
		end
	end

	// ------------------------------------------------------------
	// Literal extraction
	// ------------------------------------------------------------
	logic [15:0] lit_cut;
	always_comb begin
		case (LIT_KIND)
			LK_5:    lit_cut = LIT_FIELD & LIT5_MASK;
			LK_10:   lit_cut = LIT_FIELD & LIT10_MASK;
			LK_8:    lit_cut = LIT_FIELD & LIT8_MASK;
			LK_16:   lit_cut = LIT_FIELD;
			LK_HOLD: lit_cut = LIT_FIELD & HOLD_MASK;
			LK_JUMP: lit_cut = LIT_FIELD;
			default: lit_cut = 16'h0000;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LIT_OUT_VALID <= 1'b0;
			LIT_VALUE <= 16'h0000;
			JUMP_OFFSET <= 16'h0000;
		end else begin
			LIT_OUT_VALID <= LIT_VALID && LIT_KIND <= LK_JUMP;
			if (LIT_VALID)
				LIT_VALUE <= lit_cut;
			if (LIT_VALID && LIT_KIND == LK_JUMP)
				JUMP_OFFSET <= LIT_FIELD;
		end
	end

endmodule
`default_nettype wire

/* File: tb/agen_checker.sv */
// Port assertions for the address generator
`timescale 1ns/1ps
`default_nettype none
module agen_checker (
	input wire logic        SYS_CLK, RST_N, REQ_VALID, SRC_EN, DST_EN, MAC_VALID, CORE_WR_EN,
	input wire logic        LIT_VALID, X_RD_VALID, X_WR_VALID, REV_ON, Y_RD_VALID, MAC_FAULT,
	input wire logic        LIT_OUT_VALID,
	input wire logic [2:0]  SRC_MODE, MAC_X_OP, LIT_KIND,
	input wire logic [3:0]  MAC_X_PTR,
	input wire logic [12:0] SRC_FILE,
	input wire logic [15:0] LIT_FIELD, X_RD_ADDR, Y_RD_ADDR, LIT_VALUE, JUMP_OFFSET
);
	import addr_gen_pkg::*;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_step2; MAC_VALID && MAC_X_PTR == 4'h8 && MAC_X_OP == MO_POST2 && !CORE_WR_EN; endsequence
	sequence s_gap; !MAC_VALID && !REQ_VALID && !CORE_WR_EN; endsequence
	sequence s_ind8; MAC_VALID && MAC_X_PTR == 4'h8 && MAC_X_OP == MO_IND; endsequence
	a_mac_post_step: assert property (s_step2 ##1 s_gap ##1 s_ind8 |=>
		X_RD_ADDR == $past(X_RD_ADDR, 2) + MAC_STEP2) else $error("mac step");
	a_file_addr: assert property (REQ_VALID && SRC_EN && SRC_MODE == AM_FILE && !MAC_VALID |=>
		X_RD_VALID && X_RD_ADDR == {3'h0, $past(SRC_FILE)}) else $error("file address");
	a_mac_x_set: assert property (MAC_VALID && MAC_X_PTR[3:1] != 3'h4 |=>
		MAC_FAULT && !X_RD_VALID && !Y_RD_VALID) else $error("mac pointer set");
	a_mac_index: assert property (MAC_VALID && MAC_X_PTR == MAC_X_PTR_A && MAC_X_OP == MO_INDEX
		|=> MAC_FAULT) else $error("mac index");
	a_y_word_mac: assert property (Y_RD_VALID |-> !Y_RD_ADDR[0] && $past(MAC_VALID))
		else $error("y read");
	a_hold_lit: assert property (LIT_VALID && LIT_KIND == LK_HOLD |=>
		LIT_OUT_VALID && LIT_VALUE == ($past(LIT_FIELD) & HOLD_MASK)) else $error("hold literal");
	a_jump_lit: assert property (LIT_VALID && LIT_KIND == LK_JUMP |=>
		JUMP_OFFSET == $past(LIT_FIELD)) else $error("jump literal");
	a_lit_short: assert property (LIT_VALID && LIT_KIND == LK_5 |=>
		LIT_VALUE == ($past(LIT_FIELD) & LIT5_MASK)) else $error("short literal");
	a_rev_write: assert property (REV_ON |-> X_WR_VALID && $past(REQ_VALID && DST_EN))
		else $error("reversed write");
endmodule
bind address_generator_ea agen_checker u_agen_checker (.*);
`default_nettype wire

/* File: tb/mem_port_model.sv */
// Data memory port model counting generated accesses
`timescale 1ns/1ps
`default_nettype none
module mem_port_model (
	input wire logic clk, rd_x, rd_y, wr_x,
	output int       accesses = 0
);
	always @(posedge clk) accesses <= accesses + int'(rd_x) + int'(rd_y) + int'(wr_x);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the address generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %s expected %h seen %h", n, e, a); end end
module testbench;
	import addr_gen_pkg::*;
	logic SYS_CLK, RST_N, HSEL, HWRITE, CORE_WR_EN, REQ_VALID, SRC_EN, DST_EN, MAC_VALID, LIT_VALID;
	logic HREADYOUT, HRESP, X_RD_VALID, X_WR_VALID, X_CIRC_ON, REV_ON, Y_RD_VALID, Y_CIRC_ON;
	logic MAC_FAULT, LIT_OUT_VALID, REQ_PSPACE, DST_TO_DEFAULT_WORK_REGISTER;
	logic [1:0] HTRANS;
	logic [2:0] SRC_MODE, DST_MODE, MAC_X_OP, MAC_Y_OP, LIT_KIND;
	logic [3:0] CORE_WR_SEL, SRC_PTR, DST_PTR, OFS_REG, MAC_X_PTR, MAC_Y_PTR;
	logic [12:0] SRC_FILE;
	logic [15:0] CORE_WR_DATA, LIT_OFS, MODIFIER, LIT_FIELD, X_RD_ADDR, X_WR_ADDR, Y_RD_ADDR;
	logic [15:0] LIT_VALUE, JUMP_OFFSET, p, e, h;
	logic [31:0] HADDR, HWDATA, HRDATA, seed, r;
	logic [15:0] w [16];
	logic [15:0] lm [6] = '{LIT5_MASK, LIT10_MASK, LIT8_MASK, 16'hffff, HOLD_MASK, 16'hffff};
	logic [6:0] bad [3] = '{{4'h8, MO_INDEX}, {4'h7, MO_IND}, {4'hc, MO_POST2}};
	int failures = 0, tests_run = 0, accesses;
	address_generator_ea u_address_generator_ea (.*, .HSIZE(3'h2), .HREADY(HREADYOUT),
		.REQ_BYTE(1'b0), .DST_FILE(SRC_FILE));
	mem_port_model u_mem_port_model (.clk(SYS_CLK), .rd_x(X_RD_VALID), .rd_y(Y_RD_VALID),
		.wr_x(X_WR_VALID), .accesses(accesses));
	initial begin
		SYS_CLK = 0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic final_report;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic hrdy;
		int n;
		n = 0;
		@(posedge SYS_CLK);
		while (HREADYOUT !== 1'b1) begin
			n++;
			if (n > 20) begin
				failures++;
				final_report;
			end
			@(posedge SYS_CLK);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] ix, input logic [15:0] d);
		HSEL <= 1; HTRANS <= 2'h2; HWRITE <= wr; HADDR <= {22'h0, ix, 2'h0};
		hrdy;
		HSEL <= 0; HTRANS <= 2'h0; HWDATA <= {16'h0, d};
		hrdy;
		r = HRDATA;
	endtask
	task automatic rchk(input logic [7:0] ix, input logic [15:0] x);
		ahb(0, ix, 16'h0);
		`CHK("register", {17'h0, x}, {HRESP, r})
	endtask
	task automatic cw(input logic [3:0] s, input logic [15:0] d);
		@(posedge SYS_CLK);
		CORE_WR_EN <= 1; CORE_WR_SEL <= s; CORE_WR_DATA <= d; w[s] = d;
		@(posedge SYS_CLK);
		CORE_WR_EN <= 0;
	endtask
	task automatic req(input logic [2:0] m, input logic [3:0] pt, input logic [15:0] x);
		@(posedge SYS_CLK);
		REQ_VALID <= 1; SRC_EN <= 1; SRC_MODE <= m; SRC_PTR <= pt;
		@(posedge SYS_CLK);
		REQ_VALID <= 0;
		#1 `CHK("x read", {1'b1, x}, {X_RD_VALID, X_RD_ADDR})
	endtask
	task automatic mac(input logic [3:0] xp, input logic [2:0] xo, input logic [3:0] yp,
		input logic [2:0] yo);
		@(posedge SYS_CLK);
		MAC_VALID <= 1; MAC_X_PTR <= xp; MAC_X_OP <= xo; MAC_Y_PTR <= yp; MAC_Y_OP <= yo;
		@(posedge SYS_CLK);
		MAC_VALID <= 0;
		#1;
	endtask
	initial begin
		seed = 32'h73504b16;
		{RST_N, HSEL, HWRITE, CORE_WR_EN, REQ_VALID, SRC_EN, DST_EN, MAC_VALID, LIT_VALID} = '0;
		{HADDR, HWDATA, HTRANS, SRC_MODE, DST_MODE, MAC_X_OP, MAC_Y_OP, LIT_KIND, SRC_FILE} = '0;
		{CORE_WR_SEL, SRC_PTR, DST_PTR, OFS_REG, MAC_X_PTR, MAC_Y_PTR, LIT_OFS, MODIFIER} = '0;
		{CORE_WR_DATA, LIT_FIELD, REQ_PSPACE, DST_TO_DEFAULT_WORK_REGISTER} = '0;
		foreach (w[i]) w[i] = 16'h0;
		w[15] = STACK_RESET;
		repeat (12) @(posedge SYS_CLK);
		RST_N <= 1;
		rchk(IDX_MODE_CTRL, REG_RESET);
		ahb(1, IDX_MODE_CTRL, 16'hffff);
		rchk(IDX_MODE_CTRL, MODE_CTRL_MASK);
		ahb(1, IDX_MODE_CTRL, 16'h0);
		p = 16'(rnd()) & 16'hfffe;
		cw(2, p); cw(3, 16'h0020); cw(8, p); cw(12, 16'h0010);
		OFS_REG <= 4'h3; LIT_OFS <= 16'h0010; MODIFIER <= 16'h0002;
		req(AM_REGOFS, 2, p + 16'h20);
		req(AM_LITOFS, 2, p + 16'h10);
		req(AM_POST, 2, p);
		req(AM_IND, 2, p + 16'h2);
		MODIFIER <= 16'hfffc;
		req(AM_PRE, 2, p - 16'h2);
		req(AM_DIRECT, 4'h5, 16'h000a);
		e = 16'(rnd()) & 16'h1fff;
		SRC_FILE <= e[12:0];
		req(AM_FILE, 0, e);
		for (int i = 0; i < 2; i++) begin
			ahb(1, IDX_MODE_CTRL, (i != 0) ? 16'h800f : 16'h8002);
			req(AM_IND, 2, p - 16'h2);
			`CHK("x circular", 1'(i == 0), X_CIRC_ON)
		end
		ahb(1, IDX_MODE_CTRL, 16'h40a0);
		for (int k = 3; k >= 0; k--) begin
			mac(4'h8, 3'(k), 4'ha, MO_IND);
			`CHK("mac x", {1'b1, w[8]}, {X_RD_VALID, X_RD_ADDR})
			`CHK("mac y", {2'b11, w[10]}, {Y_RD_VALID, Y_CIRC_ON, Y_RD_ADDR})
			w[8] = w[8] + 16'(2 * k);
		end
		mac(4'h9, MO_INDEX, 4'hb, MO_INDEX);
		`CHK("mac index", {2'b11, w[12], w[12]}, {X_RD_VALID, Y_RD_VALID, X_RD_ADDR, Y_RD_ADDR})
		foreach (bad[i]) begin
			mac(bad[i][6:3], bad[i][2:0], 4'ha, MO_IND);
			`CHK("mac refused", 3'b100, {MAC_FAULT, X_RD_VALID, Y_RD_VALID})
		end
		for (int i = 0; i < 6; i++) begin
			e = 16'(rnd());
			LIT_FIELD <= e; LIT_KIND <= 3'(i); LIT_VALID <= 1;
			if (i == 4) h = e & HOLD_MASK;
			@(posedge SYS_CLK);
			LIT_VALID <= 0;
			#1 `CHK("literal", e & lm[i], (i == 5) ? JUMP_OFFSET : LIT_VALUE)
		end
		rchk(IDX_HOLD_COUNT, h);
		ahb(1, IDX_REV_MOD, 16'h8004);
		ahb(1, IDX_MODE_CTRL, 16'h020f);
		MODIFIER <= 16'h0002; DST_PTR <= 4'h2; DST_EN <= 1; DST_TO_DEFAULT_WORK_REGISTER <= 1;
		for (int i = 0; i < 3; i++) begin
			REQ_PSPACE <= (i == 1); DST_MODE <= (i == 2) ? AM_FILE : AM_POST; REQ_VALID <= 1;
			@(posedge SYS_CLK);
			REQ_VALID <= 0;
			h = (i == 2) ? 16'h0000 : p - 16'h2 + 16'(2 * i);
			#1 `CHK("x write", {1'b1, h}, {X_WR_VALID, X_WR_ADDR})
			`CHK("reversed write", 1'(i == 0), REV_ON)
		end
		@(posedge SYS_CLK);
		#1 `CHK("memory accesses", 25, accesses)
		final_report;
	end
endmodule
`default_nettype wire
